// file: rtl/acl_entry_match.sv
// match logic for one filter_entry with its APB registers
// assumes: frame fields valid in the cycle frm_valid is high
`default_nettype none
module acl_entry_match (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // frame from classification
  input  wire logic        frm_valid,
  input  wire logic        frm_is_etype,
  input  wire logic        frm_is_tcp,
  input  wire logic        frm_is_udp,
  input  wire logic [15:0] frm_sport,
  input  wire logic [15:0] frm_dport,
  input  wire logic [5:0]  frm_flags,
  input  wire logic [15:0] frm_etype,
  // result
  output logic             match_valid,
  output logic             match_hit
);
  import acl_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] sport;
    logic [31:0] dport;
    logic [11:0] flags;
    logic [15:0] etype;
    logic        rej;
    logic [31:0] hits;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        mvalid;
    logic        mhit;
  } acl_state_t;

  acl_state_t s_q, s_d;

  logic       sp_hit, dp_hit;
  logic [5:0] fl_ok;
  logic       wr_acc, rd_acc, cls_tcp, cls_udp, l4_ok, et_ok, all_ok;
  logic       cls_et;

  acl_port_cmp u_src (
    .mode    (s_q.ctrl[ACL_CTRL_SMODE_LSB +: 2]),
    .lo      (s_q.sport[15:0]),
    .hi      (s_q.sport[31:16]),
    .port_in (frm_sport),
    .hit     (sp_hit)
  );
  acl_port_cmp u_dst (
    .mode    (s_q.ctrl[ACL_CTRL_DMODE_LSB +: 2]),
    .lo      (s_q.dport[15:0]),
    .hi      (s_q.dport[31:16]),
    .port_in (frm_dport),
    .hit     (dp_hit)
  );

  // ****************************************
  // flag criteria, fin syn rst psh ack urg
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < ACL_NFLAGS; g++) begin : g_flag
      assign fl_ok[g] = s_q.flags[2*g+1] ||
                        (s_q.flags[2*g] == frm_flags[g]);
    end
  endgenerate

  always_comb begin
    cls_et  = s_q.ctrl[ACL_CTRL_CLASS_LSB +: 2] == ACL_CLASS_ETYPE;
    cls_tcp = s_q.ctrl[ACL_CTRL_CLASS_LSB +: 2] == ACL_CLASS_TCP;
    cls_udp = s_q.ctrl[ACL_CTRL_CLASS_LSB +: 2] == ACL_CLASS_UDP;
    // l4 criteria only for tcp/udp entries, flags only for tcp
    l4_ok = 1'b1;
    if (cls_tcp) begin
      l4_ok = frm_is_tcp && sp_hit && dp_hit && (&fl_ok);
    end else if (cls_udp) begin
      l4_ok = frm_is_udp && sp_hit && dp_hit;
    end
    // ethertype only checked for ethertype class
    et_ok = 1'b1;
    if (cls_et) begin
      et_ok = frm_is_etype && (!s_q.ctrl[ACL_CTRL_EMODE_LSB] ||
                               frm_etype == s_q.etype);
    end
    all_ok = l4_ok && et_ok && s_q.ctrl[ACL_CTRL_EN_LSB];
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d        = s_q;
    wr_acc     = psel && penable && pwrite && !s_q.ready;
    rd_acc     = psel && penable && !pwrite && !s_q.ready;
    s_d.ready  = psel && penable && !s_q.ready;
    s_d.err    = 1'b0;
    s_d.mvalid = frm_valid;
    s_d.mhit   = frm_valid && all_ok;
    if (frm_valid && all_ok) begin
      s_d.hits = s_q.hits + 32'h0000_0001;
    end
    if (wr_acc) begin
      if (paddr == ACL_CTRL_ADDR) begin
        s_d.ctrl = pwdata;
      end else if (paddr == ACL_SPORT_ADDR) begin
        s_d.sport = pwdata;
      end else if (paddr == ACL_DPORT_ADDR) begin
        s_d.dport = pwdata;
      end else if (paddr == ACL_FLAGS_ADDR) begin
        s_d.flags = pwdata[11:0];
      end else if (paddr == ACL_ETYPE_ADDR) begin
        // out-of-range or reserved codes refused, old value kept
        if (pwdata[15:0] < ACL_ETYPE_MIN || pwdata[15:0] == ACL_ETYPE_IPV4
            || pwdata[15:0] == ACL_ETYPE_ARP
            || pwdata[15:0] == ACL_ETYPE_IPV6) begin
          s_d.rej = 1'b1;
          s_d.err = 1'b1;
        end else begin
          s_d.etype = pwdata[15:0];
          s_d.rej   = 1'b0;
        end
      end else if (paddr == ACL_HITS_ADDR) begin
        s_d.hits = 32'h0000_0000;
      end else if (paddr != ACL_STAT_ADDR) begin
        s_d.err = 1'b1;
      end
    end
    if (rd_acc) begin
      s_d.rdata = 32'h0000_0000;
      if (paddr == ACL_CTRL_ADDR) begin
        s_d.rdata = s_q.ctrl;
      end else if (paddr == ACL_SPORT_ADDR) begin
        s_d.rdata = s_q.sport;
      end else if (paddr == ACL_DPORT_ADDR) begin
        s_d.rdata = s_q.dport;
      end else if (paddr == ACL_FLAGS_ADDR) begin
        s_d.rdata = {20'h00000, s_q.flags};
      end else if (paddr == ACL_ETYPE_ADDR) begin
        s_d.rdata = {16'h0000, s_q.etype};
      end else if (paddr == ACL_STAT_ADDR) begin
        s_d.rdata = {30'h0, s_q.rej, s_q.mhit};
      end else if (paddr == ACL_HITS_ADDR) begin
        s_d.rdata = s_q.hits;
      end else begin
        s_d.err = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '{ctrl: ACL_CTRL_RST, sport: 32'h0000_0000,
               dport: 32'h0000_0000, flags: ACL_FLAGS_RST[11:0],
               etype: ACL_ETYPE_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata      = s_q.rdata;
  assign pready      = s_q.ready;
  assign pslverr     = s_q.err;
  assign match_valid = s_q.mvalid;
  assign match_hit   = s_q.mhit;

  // ****************************************
  // checks
  // ****************************************
  a_hit_valid: assert property (@(posedge clk_sys) disable iff (reset)
    match_hit |-> match_valid) else $error("hit without valid");
  a_dis_nohit: assert property (@(posedge clk_sys) disable iff (reset)
    !s_q.ctrl[ACL_CTRL_EN_LSB] && $stable(s_q.ctrl) |=> !match_hit)
    else $error("disabled entry hit");
  a_src_one: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.ctrl[5:4] == 2'b01
      && frm_sport != s_q.sport[15:0] |=> !match_hit)
    else $error("single source mismatch hit");
  a_src_range: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_udp && s_q.ctrl[5:4] == 2'b10
      && frm_sport > s_q.sport[31:16] |=> !match_hit)
    else $error("source above range hit");
  a_dst_range: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_udp && s_q.ctrl[7:6] == 2'b10
      && frm_dport < s_q.dport[15:0] |=> !match_hit)
    else $error("destination below range hit");
  a_dst_one: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.ctrl[7:6] == 2'b01
      && frm_dport != s_q.dport[15:0] |=> !match_hit)
    else $error("single destination mismatch hit");
  a_fin_zero: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.flags[1:0] == 2'b00 && frm_flags[0]
      |=> !match_hit) else $error("fin zero hit");
  a_urg_one: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.flags[11:10] == 2'b01 && !frm_flags[5]
      |=> !match_hit) else $error("urg one hit");
  a_etype_val: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_et && s_q.ctrl[8] && frm_etype != s_q.etype
      |=> !match_hit) else $error("ethertype mismatch hit");
  a_etype_rej: assert property (@(posedge clk_sys) disable iff (reset)
    wr_acc && paddr == ACL_ETYPE_ADDR && pwdata[15:0] == ACL_ETYPE_IPV4
      |=> pslverr && $stable(s_q.etype)) else $error("ipv4 code taken");
  a_apb_ready: assert property (@(posedge clk_sys) disable iff (reset)
    psel && penable && !pready |=> pready) else $error("apb stalled");
  a_err_ready: assert property (@(posedge clk_sys) disable iff (reset)
    pslverr |-> pready) else $error("error without ready");
  a_bad_addr: assert property (@(posedge clk_sys) disable iff (reset)
    psel && penable && !pready && paddr > ACL_HITS_ADDR |=> pslverr)
    else $error("unmapped access accepted");
  a_hit_cnt: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && all_ok && !(wr_acc && paddr == ACL_HITS_ADDR)
      |=> s_q.hits == $past(s_q.hits) + 32'h0000_0001)
    else $error("hit not counted");
  a_hits_clr: assert property (@(posedge clk_sys) disable iff (reset)
    wr_acc && paddr == ACL_HITS_ADDR |=> s_q.hits == 32'h0000_0000)
    else $error("hit counter not cleared");
  a_valid_lat: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid |=> match_valid) else $error("result missing");
  a_valid_idle: assert property (@(posedge clk_sys) disable iff (reset)
    !frm_valid |=> !match_valid) else $error("result without frame");

  // ****************************************
  // per-criterion checks
  // ****************************************
  // flag checks only look at tcp entries, where flags take part
  a_fin_one: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.flags[1:0] == 2'b01 && !frm_flags[0]
      |=> !match_hit) else $error("fin one hit");
  a_syn_zero: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.flags[3:2] == 2'b00 && frm_flags[1]
      |=> !match_hit) else $error("syn zero hit");
  a_syn_one: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.flags[3:2] == 2'b01 && !frm_flags[1]
      |=> !match_hit) else $error("syn one hit");
  a_rst_zero: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.flags[5:4] == 2'b00 && frm_flags[2]
      |=> !match_hit) else $error("rst zero hit");
  a_rst_one: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.flags[5:4] == 2'b01 && !frm_flags[2]
      |=> !match_hit) else $error("rst one hit");
  a_psh_zero: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.flags[7:6] == 2'b00 && frm_flags[3]
      |=> !match_hit) else $error("psh zero hit");
  a_psh_one: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.flags[7:6] == 2'b01 && !frm_flags[3]
      |=> !match_hit) else $error("psh one hit");
  a_ack_zero: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.flags[9:8] == 2'b00 && frm_flags[4]
      |=> !match_hit) else $error("ack zero hit");
  a_ack_one: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.flags[9:8] == 2'b01 && !frm_flags[4]
      |=> !match_hit) else $error("ack one hit");
  a_urg_zero: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.flags[11:10] == 2'b00 && frm_flags[5]
      |=> !match_hit) else $error("urg zero hit");
  a_tcp_class: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && !frm_is_tcp |=> !match_hit)
    else $error("non-tcp frame hit tcp entry");
  a_udp_class: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_udp && !frm_is_udp |=> !match_hit)
    else $error("non-udp frame hit udp entry");
  a_et_class: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_et && !frm_is_etype |=> !match_hit)
    else $error("non-ethertype frame hit");
  a_et_any: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_et && frm_is_etype && !s_q.ctrl[8]
      && s_q.ctrl[31] |=> match_hit) else $error("ethertype any missed");
  a_any_class: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && s_q.ctrl[1:0] == 2'b00 && s_q.ctrl[31] |=> match_hit)
    else $error("class any missed");
  a_src_any: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_udp && frm_is_udp && s_q.ctrl[5:4] == 2'b00
      && dp_hit && s_q.ctrl[31] |=> match_hit)
    else $error("source any missed");
  a_dst_any: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_udp && frm_is_udp && s_q.ctrl[7:6] == 2'b00
      && sp_hit && s_q.ctrl[31] |=> match_hit)
    else $error("destination any missed");
  a_src_low: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.ctrl[5:4] == 2'b10
      && frm_sport < s_q.sport[15:0] |=> !match_hit)
    else $error("source below range hit");
  a_dst_high: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_tcp && s_q.ctrl[7:6] == 2'b10
      && frm_dport > s_q.dport[31:16] |=> !match_hit)
    else $error("destination above range hit");
  // bounds themselves must hit, only for a well-formed range
  a_src_edge: assert property (@(posedge clk_sys) disable iff (reset)
    s_q.ctrl[5:4] == 2'b10 && s_q.sport[15:0] <= s_q.sport[31:16]
      && (frm_sport == s_q.sport[15:0] || frm_sport == s_q.sport[31:16])
      |-> sp_hit) else $error("source range bound missed");
  a_dst_edge: assert property (@(posedge clk_sys) disable iff (reset)
    s_q.ctrl[7:6] == 2'b10 && s_q.dport[15:0] <= s_q.dport[31:16]
      && (frm_dport == s_q.dport[15:0] || frm_dport == s_q.dport[31:16])
      |-> dp_hit) else $error("destination range bound missed");
  a_src_never: assert property (@(posedge clk_sys) disable iff (reset)
    frm_valid && cls_udp && s_q.ctrl[5:4] == 2'b11 |=> !match_hit)
    else $error("reserved source mode hit");
  c_src_edge: cover property (@(posedge clk_sys)
    frm_valid && s_q.ctrl[5:4] == 2'b10 && frm_sport == s_q.sport[31:16]);
  c_tcp_hit: cover property (@(posedge clk_sys) cls_tcp && match_hit);
  c_udp_hit: cover property (@(posedge clk_sys) cls_udp && match_hit);
  c_et_hit: cover property (@(posedge clk_sys) cls_et && match_hit);
  c_rej: cover property (@(posedge clk_sys) s_q.rej);
endmodule
`default_nettype wire

// file: shared/acl_pkg.sv
// package of constants for the filter_entry match block
// assumes: single 100 MHz clock, APB register access
// Functional notes
// - source port don't-care ignores frame source port
// - single source mode: 16-bit value, match on equality
// - range source mode: match when source port lies in range
// - destination port don't-care ignores frame destination port
// - single destination mode: 16-bit value, match on equality
// - range destination mode: match when destination port in range
// - FIN criterion: must be clear, must be set, or ignored
// - SYN criterion: must be clear, must be set, or ignored
// - RST criterion: must be clear, must be set, or ignored
// - PSH criterion: must be clear, must be set, or ignored
// - ACK criterion: must be clear, must be set, or ignored
// - URG criterion: must be clear, must be set, or ignored
// - EtherType criterion used only for EtherType frame class entries
// - EtherType don't-care ignores frame EtherType
// - single EtherType value 0x600..0xFFFF, match on equality; the code also refuses 0x0800, 0x0806 and 0x86DD
// - port and flag criteria apply only to TCP or UDP entries; the code applies the flag criteria to TCP entries only
`default_nettype none
package acl_pkg;
  // register byte addresses
  localparam logic [11:0] ACL_CTRL_ADDR  = 12'h000;
  localparam logic [11:0] ACL_SPORT_ADDR = 12'h004;
  localparam logic [11:0] ACL_DPORT_ADDR = 12'h008;
  localparam logic [11:0] ACL_FLAGS_ADDR = 12'h00C;
  localparam logic [11:0] ACL_ETYPE_ADDR = 12'h010;
  localparam logic [11:0] ACL_STAT_ADDR  = 12'h014;
  localparam logic [11:0] ACL_HITS_ADDR  = 12'h018;
  // control field positions
  localparam int ACL_CTRL_CLASS_LSB = 0;  // 2 bits
  localparam int ACL_CTRL_SMODE_LSB = 4;  // 2 bits
  localparam int ACL_CTRL_DMODE_LSB = 6;  // 2 bits
  localparam int ACL_CTRL_EMODE_LSB = 8;  // 1 bit
  localparam int ACL_CTRL_EN_LSB    = 31;
  // flag criteria: two bits per flag, fin at bit 0
  localparam int ACL_NFLAGS = 6;
  // ethertype limits and forbidden codes
  localparam logic [15:0] ACL_ETYPE_MIN  = 16'h0600;
  localparam logic [15:0] ACL_ETYPE_IPV4 = 16'h0800;
  localparam logic [15:0] ACL_ETYPE_ARP  = 16'h0806;
  localparam logic [15:0] ACL_ETYPE_IPV6 = 16'h86DD;
  // reset values
  localparam logic [31:0] ACL_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] ACL_FLAGS_RST = 32'h0000_0AAA;
  localparam logic [15:0] ACL_ETYPE_RST = 16'h0600;
  typedef enum logic [1:0] {
    ACL_PMODE_ANY, ACL_PMODE_ONE, ACL_PMODE_RANGE, ACL_PMODE_RSVD
  } acl_pmode_t;
  typedef enum logic [1:0] {
    ACL_FLAG_ZERO, ACL_FLAG_ONE, ACL_FLAG_ANY, ACL_FLAG_ANY2
  } acl_flag_t;
  typedef enum logic [1:0] {
    ACL_CLASS_ANY, ACL_CLASS_ETYPE, ACL_CLASS_TCP, ACL_CLASS_UDP
  } acl_class_t;
endpackage
`default_nettype wire

// file: rtl/acl_port_cmp.sv
// one port criterion: don't-care, single value or inclusive range
// assumes: combinational inputs, result registered by the caller
`default_nettype none
module acl_port_cmp (
  // criterion
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] lo,
  input  wire logic [15:0] hi,
  // frame field
  input  wire logic [15:0] port_in,
  // result
  output logic             hit
);
  import acl_pkg::*;
  always_comb begin
    case (acl_pmode_t'(mode))
      ACL_PMODE_ONE:   hit = (port_in == lo);
      ACL_PMODE_RANGE: hit = (port_in >= lo) && (port_in <= hi);
      ACL_PMODE_ANY:   hit = 1'b1;
      default:         hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: verif/acl_frm_src.sv
// model of the receive and classification path feeding one filter_entry
// assumes: send is called from the bench, one frame per call
`default_nettype none
module acl_frm_src (
  // clock
  input  wire logic   clk_sys,
  // frame towards the entry
  output logic        frm_valid,
  output logic        frm_is_etype,
  output logic        frm_is_tcp,
  output logic        frm_is_udp,
  output logic [15:0] frm_sport,
  output logic [15:0] frm_dport,
  output logic [5:0]  frm_flags,
  output logic [15:0] frm_etype
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frm_valid = 1'h0;
    {frm_is_udp, frm_is_tcp, frm_is_etype} = 3'h0;
    {frm_sport, frm_dport, frm_flags, frm_etype} = 54'h0;
  end
  task automatic send(input logic [2:0] cls, input logic [15:0] sp, dp,
                      input logic [5:0] fl, input logic [15:0] et);
    @(posedge clk_sys);
    frm_valid <= 1'h1;
    {frm_is_udp, frm_is_tcp, frm_is_etype} <= cls;
    {frm_sport, frm_dport, frm_flags, frm_etype} <= {sp, dp, fl, et};
    @(posedge clk_sys);
    frm_valid <= 1'h0;
    // port, flag and etype fields are inverted between frames, never a stale copy
    {frm_sport, frm_dport, frm_flags, frm_etype} <= ~{sp, dp, fl, et};
  endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for one filter_entry match block
// assumes: apb answers with one wait state, result one cycle after frame
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import acl_pkg::*;
  logic clk_sys = 1'h0, reset = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, match_valid, match_hit;
  wire logic frm_valid, frm_is_etype, frm_is_tcp, frm_is_udp;
  wire logic [15:0] frm_sport, frm_dport, frm_etype;
  wire logic [5:0] frm_flags;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  logic [31:0] cfg [5];
  always #5 clk_sys = ~clk_sys;
  acl_entry_match acl_entry_match_i (.clk_sys, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .frm_valid,
    .frm_is_etype, .frm_is_tcp, .frm_is_udp, .frm_sport, .frm_dport,
    .frm_flags, .frm_etype, .match_valid, .match_hit);
  acl_frm_src acl_frm_src_i (.clk_sys, .frm_valid, .frm_is_etype,
    .frm_is_tcp, .frm_is_udp, .frm_sport, .frm_dport, .frm_flags,
    .frm_etype);
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // *****************************
  // bus and compare helpers
  // *****************************
  task automatic cmp(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic logic pm(input logic [1:0] m, input logic [31:0] r,
                              input logic [15:0] p);
    case (m)
      2'h0: pm = 1'h1;
      2'h1: pm = p == r[15:0];
      2'h2: pm = p >= r[15:0] && p <= r[31:16];
      default: pm = 1'h0;
    endcase
  endfunction
  function automatic logic exp_hit(input logic [2:0] cls,
    input logic [15:0] sp, dp, input logic [5:0] fl, input logic [15:0] et);
    logic l4, f;
    l4 = pm(cfg[0][5:4], cfg[1], sp) && pm(cfg[0][7:6], cfg[2], dp);
    f = 1'h1;
    for (int i = 0; i < 6; i++)
      if (!cfg[3][2*i+1] && cfg[3][2*i] != fl[i]) f = 1'h0;
    case (cfg[0][1:0])
      2'h1: exp_hit = cls[0] && (!cfg[0][8] || et == cfg[4][15:0]);
      2'h2: exp_hit = cls[1] && l4 && f;
      2'h3: exp_hit = cls[2] && l4;
      default: exp_hit = 1'h1;
    endcase
    exp_hit = exp_hit && cfg[0][31];
  endfunction
  function automatic logic [15:0] pick(input logic [31:0] r);
    case ($urandom % 5)
      0: pick = r[15:0];
      1: pick = r[31:16];
      2: pick = r[15:0] - 16'h1;
      3: pick = r[31:16] + 16'h1;
      default: pick = 16'($urandom);
    endcase
  endfunction
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // *****************************
  // main sequence
  // *****************************
  initial begin
    logic [31:0] rd;
    logic er;
    logic [2:0] cls;
    logic [15:0] sp, dp, et;
    logic [5:0] fl;
    logic [15:0] bad [4];
    int hits;
    hits = 0;
    rd = $urandom(32'h269E1EEC);
    repeat (16) @(posedge clk_sys);
    reset <= 1'h0;
    cfg = '{ACL_CTRL_RST, 32'h0, 32'h0, ACL_FLAGS_RST, 32'h600};
    for (int i = 0; i < 5; i++) begin
      apb(1'h0, 12'(4 * i), 32'h0, rd, er);
      cmp(rd, cfg[i]);
    end
    $display("test reset_values done");
    bad = '{ACL_ETYPE_IPV4, ACL_ETYPE_ARP, ACL_ETYPE_IPV6, 16'h05FF};
    foreach (bad[i]) begin
      apb(1'h1, ACL_ETYPE_ADDR, {16'h0, bad[i]}, rd, er);
      cmp(32'(er), 32'h1);
      apb(1'h0, ACL_ETYPE_ADDR, 32'h0, rd, er);
      cmp(rd, 32'h600);
      apb(1'h0, ACL_STAT_ADDR, 32'h0, rd, er);
      cmp(32'(rd[1]), 32'h1);
    end
    apb(1'h0, 12'h01C, 32'h0, rd, er);
    cmp(32'(er), 32'h1);
    $display("test refusals done");
    for (int n = 0; n < 400; n++) begin
      if (n % 16 == 0) begin
        cfg[0] = {($urandom % 8) != 0, 22'h0, 1'($urandom), 4'($urandom),
                  2'h0, 2'($urandom)};
        for (int k = 1; k < 3; k++) begin
          cfg[k][15:0] = ($urandom % 4 == 0) ? 16'h0 : 16'($urandom);
          cfg[k][31:16] = cfg[k][15:0] + 16'($urandom % 9);
          if ($urandom % 4 == 0) cfg[k][31:16] = 16'hFFFF;
        end
        cfg[3] = 32'($urandom % 4096);
        do et = 16'($urandom);
        while (et < 16'h600 || et == 16'h800 || et == 16'h806 ||
               et == 16'h86DD);
        cfg[4] = {16'h0, et};
        for (int k = 0; k < 5; k++) begin
          apb(1'h1, 12'(4 * k), cfg[k], rd, er);
          cmp(32'(er), 32'h0);
        end
      end
      cls = 3'h1 << ($urandom % 4);
      sp = pick(cfg[1]);
      dp = pick(cfg[2]);
      fl = 6'($urandom);
      et = ($urandom % 2) ? cfg[4][15:0] : 16'($urandom);
      acl_frm_src_i.send(cls, sp, dp, fl, et);
      #1;
      cmp(32'(match_valid), 32'h1);
      cmp(32'(match_hit), 32'(exp_hit(cls, sp, dp, fl, et)));
      hits += int'(exp_hit(cls, sp, dp, fl, et));
    end
    $display("test random_frames done");
    apb(1'h0, ACL_HITS_ADDR, 32'h0, rd, er);
    cmp(rd, 32'(hits));
    $display("test hit_count done");
    // any write clears the counter
    apb(1'h1, ACL_HITS_ADDR, 32'h0, rd, er);
    apb(1'h0, ACL_HITS_ADDR, 32'h0, rd, er);
    cmp(rd, 32'h0);
    // last etype write was accepted, so the reject bit is gone
    apb(1'h0, ACL_STAT_ADDR, 32'h0, rd, er);
    cmp(rd, 32'h0);
    $display("test clear_status done");
    end_of_test();
  end
endmodule
`default_nettype wire
